//--- hdl/rx_frame_filter_teardown.sv
`default_nettype none
`include "rx_filter_cfg.svh"
module rx_frame_filter_teardown
   import rx_filter_pkg::*;
#(
   parameter int BUF_BYTES = 64
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [`AW-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic mii_rx_clk,
   input wire logic mii_rx_dv,
   input wire logic mii_rx_er,
   input wire logic [3:0] mii_rxd,
   input wire logic match_hit,
   input wire logic [`CHW-1:0] match_chan,
   input wire logic addr_match_or_drop_bit,
   input wire logic ctrl_frame,
   output logic mem_byte_valid,
   output logic [7:0] mem_byte,
   output logic frame_done,
   output logic frame_accept,
   output logic [`CHW-1:0] frame_chan,
   output frame_cls_t frame_class,
   output logic [15:0] frame_len,
   output logic [`NCHAN-1:0] rx_chan_irq,
   output logic [`CHW-1:0] td_chan,
   output logic teardown_done_flag
);

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] crc_nib(input logic [31:0] c, input logic [3:0] d);
      logic [31:0] r;
      r = c;
      for (int i = 0; i < 4; i++) begin
         r = (r[0] ^ d[i]) ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction : crc_nib

   function automatic logic [`CHW-1:0] lowest(input logic [`NCHAN-1:0] v);
      logic [`CHW-1:0] r;
      r = '0;
      for (int i = `NCHAN - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = `CHW'(i);
         end
      end
      return r;
   endfunction : lowest

   localparam logic [16:0] BUF_B = 17'(BUF_BYTES);

   state_t st_q, st_d;
   mii_t pins;
   logic edge_rx, err, is_short, is_long, matched, ok, accept, dec, fl_ok;
   logic [`CHW-1:0] dchan;
   logic [15:0] bufs;
   logic [16:0] sum;
   frame_cls_t cls;
   logic [`CHW-1:0] tch;

   assign pins = '{clk: mii_rx_clk, dv: mii_rx_dv, er: mii_rx_er, d: mii_rxd};

   ////////////////////////////////////////////////////////////////////////
   // Frame classification and delivery decision, valid in S_DECIDE.
   always_comb begin
      err = st_q.code_err | st_q.odd | (st_q.crc != `CRC_RESIDUE);
      is_short = st_q.len < `MIN_LEN;
      is_long = st_q.len > st_q.maxlen;
      if (is_long) begin
         cls = err ? CLS_JABBER : CLS_OVERSIZE;
      end else if (is_short) begin
         cls = err ? CLS_FRAGMENT : CLS_UNDERSIZE;
      end else begin
         cls = err ? CLS_JABBER : CLS_PROPER;
      end
      matched = match_hit & st_q.chan_en[match_chan]
                & (~ctrl_frame | st_q.filt[`F_CTRL]);
      ok = 1'b1;
      if (ctrl_frame && !st_q.filt[`F_CTRL]) begin
         ok = 1'b0;
      end
      if (is_short && !err && !st_q.filt[`F_SHORT]) begin
         ok = 1'b0;
      end
      if (is_short && err && !(st_q.filt[`F_ERR] && st_q.filt[`F_SHORT])) begin
         ok = 1'b0;
      end
      if (!is_short && (err || is_long) && !st_q.filt[`F_ERR]) begin
         ok = 1'b0;
      end
      if (matched) begin
         dchan = match_chan;
         accept = addr_match_or_drop_bit & ok;
         if ((err || is_long) && !st_q.filt[`F_ALL]) begin
            accept = 1'b0;
         end
      end else begin
         dchan = st_q.filt[`F_CATCH];
         accept = st_q.filt[`F_ALL] & ok;
      end
      dec = (st_q.fsm == S_DECIDE) & accept;
      bufs = 16'((17'(st_q.sent) + BUF_B - 17'd1) / BUF_B);
   end

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      st_d = st_q;
      st_d.s1 = pins;
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      st_d.out_v = 1'b0;
      st_d.done_v = 1'b0;
      st_d.td_v = 1'b0;
      st_d.td_desc = 1'b0;
      st_d.rdata = '0;
      edge_rx = st_q.s2.clk & ~st_q.s3.clk;
      fl_ok = st_q.filt[`F_PASS] | (st_q.len <= `CRC_PASS_LEN) | is_long;
      tch = lowest(st_q.pend);
      unique case (st_q.fsm)
         S_IDLE: begin
            st_d.len = '0;
            st_d.sent = '0;
            st_d.held = '0;
            st_d.odd = 1'b0;
            st_d.code_err = 1'b0;
            st_d.crc = `CRC_INIT;
            if (st_q.s2.dv) begin
               st_d.fsm = S_RECV;
            end else if (st_q.pend != '0) begin
               // Teardown only runs between frames.
               st_d.pend[tch] = 1'b0;
               st_d.td_v = 1'b1;
               st_d.td_chan = tch;
               st_d.td_desc = st_q.chan_en[tch] & (st_q.head[tch] != '0);
               st_d.head[tch] = '0;
               st_d.cp[tch] = `TD_MARKER;
            end
         end
         S_RECV: begin
            if (!st_q.s2.dv) begin
               st_d.fsm = S_FLUSH;
            end else if (edge_rx) begin
               st_d.code_err = st_q.code_err | st_q.s2.er;
               st_d.crc = crc_nib(st_q.crc, st_q.s2.d);
               st_d.odd = ~st_q.odd;
               st_d.lo = st_q.s2.d;
               if (st_q.odd) begin
                  if (st_q.len != 16'hFFFF) begin
                     st_d.len = st_q.len + 16'd1;
                  end
                  // Four bytes are held back so the FCS can be stripped.
                  st_d.hold = {st_q.s2.d, st_q.lo, st_q.hold[31:8]};
                  if (st_q.held == 3'd4) begin
                     if (st_q.sent < st_q.maxlen) begin
                        st_d.out_v = 1'b1;
                        st_d.out_b = st_q.hold[7:0];
                        st_d.sent = st_q.sent + 16'd1;
                     end
                  end else begin
                     st_d.held = st_q.held + 3'd1;
                  end
               end
            end
         end
         S_FLUSH: begin
            if (st_q.held != '0 && fl_ok && st_q.sent < st_q.maxlen) begin
               st_d.out_v = 1'b1;
               st_d.out_b = st_q.hold[39 - 8 * st_q.held -: 8];
               st_d.sent = st_q.sent + 16'd1;
               st_d.held = st_q.held - 3'd1;
            end else begin
               st_d.fsm = S_DECIDE;
            end
         end
         S_DECIDE: begin
            st_d.done_v = 1'b1;
            st_d.done_acc = accept;
            st_d.done_chan = dchan;
            st_d.done_cls = cls;
            st_d.done_len = st_q.sent;
            st_d.fsm = S_IDLE;
         end
      endcase
      // Register port; a teardown command only queues, the set wins.
      if (reg_wr) begin
         unique case (reg_addr)
            `A_FILT: st_d.filt = reg_wdata[7:0];
            `A_MAXLEN: st_d.maxlen = reg_wdata[15:0];
            `A_TDOWN: st_d.pend[reg_wdata[`CHW-1:0]] = 1'b1;
            `A_CHEN: st_d.chan_en = reg_wdata[`NCHAN-1:0];
            default: begin
               if ((reg_addr & `A_ARR_MSK) == `A_HEAD) begin
                  st_d.head[reg_addr[4:2]] = reg_wdata;
               end
               if ((reg_addr & `A_ARR_MSK) == `A_CP) begin
                  st_d.cp[reg_addr[4:2]] = reg_wdata;
               end
            end
         endcase
      end
      for (int c = 0; c < `NCHAN; c++) begin
         sum = 17'(st_q.free[c]);
         if (reg_wr && reg_addr == (`A_FREE + `AW'(4 * c))) begin
            sum = sum + 17'(reg_wdata[15:0]);
         end
         if (sum[16]) begin
            sum = 17'h0_FFFF;
         end
         if (dec && dchan == `CHW'(c)) begin
            sum = (sum > 17'(bufs)) ? sum - 17'(bufs) : 17'h0_0000;
         end
         st_d.free[c] = sum[15:0];
      end
      if (reg_rd) begin
         unique case (reg_addr)
            `A_FILT: st_d.rdata = {24'h00_0000, st_q.filt};
            `A_MAXLEN: st_d.rdata = {16'h0000, st_q.maxlen};
            `A_CHEN: st_d.rdata = {24'h00_0000, st_q.chan_en};
            `A_STAT: st_d.rdata = {8'h00, st_q.pend, 3'h0, st_q.done_cls, st_q.fsm, 4'h0};
            default: begin
               if ((reg_addr & `A_ARR_MSK) == `A_HEAD) begin
                  st_d.rdata = st_q.head[reg_addr[4:2]];
               end
               if ((reg_addr & `A_ARR_MSK) == `A_CP) begin
                  st_d.rdata = st_q.cp[reg_addr[4:2]];
               end
               if ((reg_addr & `A_ARR_MSK) == `A_FREE) begin
                  st_d.rdata = {16'h0000, st_q.free[reg_addr[4:2]]};
               end
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= '0;
         st_q.fsm <= S_IDLE;
         st_q.done_cls <= CLS_PROPER;
         st_q.maxlen <= `MAXLEN_RST;
         st_q.crc <= `CRC_INIT;
      end else if (ce) begin
         st_q <= st_d;
      end
   end

   assign reg_rdata = st_q.rdata;
   assign mem_byte_valid = st_q.out_v;
   assign mem_byte = st_q.out_b;
   assign frame_done = st_q.done_v;
   assign frame_accept = st_q.done_acc;
   assign frame_chan = st_q.done_chan;
   assign frame_class = st_q.done_cls;
   assign frame_len = st_q.done_len;
   assign td_chan = st_q.td_chan;
   assign teardown_done_flag = st_q.td_desc;
   always_comb begin
      rx_chan_irq = '0;
      rx_chan_irq[st_q.td_chan] = st_q.td_v;
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks; all run on sys_clk and are held off by reset.
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   sequence decide_s;
      ce && st_q.fsm == S_DECIDE;
   endsequence
   sequence done_drop_s;
      st_q.done_v && !st_q.done_acc;
   endsequence

   tdown_marker_a: assert property (st_q.td_v |-> st_q.cp[st_q.td_chan] == `TD_MARKER)
      else $error("completion pointer lacks marker after teardown");
   tdown_head_a: assert property (st_q.td_v |-> st_q.head[st_q.td_chan] == '0)
      else $error("head pointer not cleared by teardown");
   tdown_keep_en_a: assert property (st_q.td_v && !$past(reg_wr) |->
      st_q.chan_en == $past(st_q.chan_en))
      else $error("teardown changed channel enables");
   tdown_wait_a: assert property (ce && st_q.fsm != S_IDLE |=> !st_q.td_v)
      else $error("teardown during frame reception");
   tdown_inactive_a: assert property (st_q.td_v && !st_q.chan_en[st_q.td_chan] |->
      !st_q.td_desc && rx_chan_irq != '0)
      else $error("descriptor flagged on inactive channel");
   trunc_len_a: assert property (st_q.out_v |-> st_q.sent <= st_q.maxlen)
      else $error("more than max length bytes delivered");
   short_fcs_a: assert property (ce && st_q.fsm == S_FLUSH && st_q.len <= `CRC_PASS_LEN
      && st_q.held != '0 && st_q.sent < st_q.maxlen |=> st_q.out_v)
      else $error("short frame FCS not delivered");
   filt_drop_a: assert property (decide_s and (matched && !addr_match_or_drop_bit)
      |=> done_drop_s)
      else $error("drop-bit match was delivered");
   nomatch_off_a: assert property (decide_s and (!matched && !st_q.filt[`F_ALL])
      |=> done_drop_s)
      else $error("non-matching frame delivered with accept-all off");
   proper_len_a: assert property (decide_s and (cls == CLS_PROPER) |->
      st_q.len >= `MIN_LEN && st_q.len <= st_q.maxlen && !err)
      else $error("proper class outside length window");
   free_add_a: assert property (ce && reg_wr && reg_addr == `A_FREE && st_q.fsm != S_DECIDE
      && 17'(st_q.free[0]) + 17'(reg_wdata[15:0]) < 17'h1_0000 |=>
      st_q.free[0] == $past(st_q.free[0]) + $past(reg_wdata[15:0]))
      else $error("free count write did not add");

endmodule : rx_frame_filter_teardown
`default_nettype wire

//--- hdl/rx_filter_cfg.svh
`ifndef RX_FILTER_CFG_SVH
`define RX_FILTER_CFG_SVH
`define NCHAN 8
`define CHW 3
`define AW 10
`define MAXLEN_RST 16'h05EE
`define MIN_LEN 16'h0040
`define CRC_PASS_LEN 16'h0014
`define TD_MARKER 32'hFFFF_FFFC
`define CRC_INIT 32'hFFFF_FFFF
`define CRC_POLY 32'hEDB8_8320
`define CRC_RESIDUE 32'hDEBB_20E3
`define A_FILT 10'h000
`define A_MAXLEN 10'h004
`define A_TDOWN 10'h008
`define A_CHEN 10'h00C
`define A_STAT 10'h010
`define A_HEAD 10'h100
`define A_CP 10'h140
`define A_FREE 10'h180
`define A_ARR_MSK 10'h3C0
`define F_CATCH 2:0
`define F_ALL 3
`define F_ERR 4
`define F_CTRL 5
`define F_SHORT 6
`define F_PASS 7
`endif

//--- hdl/rx_filter_pkg.sv
`default_nettype none
`include "rx_filter_cfg.svh"
package rx_filter_pkg;
   typedef struct packed {
      logic clk;
      logic dv;
      logic er;
      logic [3:0] d;
   } mii_t;
   typedef enum logic [4:0] {
      CLS_PROPER = 5'h01, CLS_OVERSIZE = 5'h02, CLS_JABBER = 5'h04,
      CLS_UNDERSIZE = 5'h08, CLS_FRAGMENT = 5'h10
   } frame_cls_t;
   typedef enum logic [3:0] {
      S_IDLE = 4'h1, S_RECV = 4'h2, S_FLUSH = 4'h4, S_DECIDE = 4'h8
   } fsm_t;
   typedef struct packed {
      mii_t s1, s2, s3;
      fsm_t fsm;
      logic odd;
      logic [3:0] lo;
      logic [15:0] len;
      logic [31:0] crc;
      logic code_err;
      logic [31:0] hold;
      logic [2:0] held;
      logic [15:0] sent;
      logic out_v;
      logic [7:0] out_b;
      logic done_v, done_acc;
      logic [`CHW-1:0] done_chan;
      frame_cls_t done_cls;
      logic [15:0] done_len;
      logic [7:0] filt;
      logic [15:0] maxlen;
      logic [`NCHAN-1:0] chan_en, pend;
      logic [`NCHAN-1:0][31:0] head, cp;
      logic [`NCHAN-1:0][15:0] free;
      logic [31:0] rdata;
      logic td_v, td_desc;
      logic [`CHW-1:0] td_chan;
   } state_t;
endpackage : rx_filter_pkg
`default_nettype wire

//--- tb/mii_phy_model.sv
`default_nettype none
module mii_phy_model
   import rx_filter_pkg::*;
(
   output var mii_t mii
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      mii = '0;
   end

   // The receive clock stands still between frames. Idle data shows the inverse of the last
   // nibble, so a receiver that samples outside a frame never sees stale frame content.
   task automatic send(input logic [7:0] q[$], input logic er);
      // The small offset keeps every pin change clear of a system clock edge.
      #7;
      for (int i = 0; i < 2 * q.size(); i++) begin
         mii.d = i[0] ? q[i / 2][7:4] : q[i / 2][3:0];
         mii.dv = 1'b1;
         mii.er = er;
         #160 mii.clk = 1'b1;
         #160 mii.clk = 1'b0;
      end
      mii.dv = 1'b0;
      mii.er = 1'b0;
      mii.d = ~mii.d;
      #640;
   endtask : send
endmodule : mii_phy_model
`default_nettype wire

//--- tb/testbench.sv
`default_nettype none
`include "rx_filter_cfg.svh"
module testbench
   import rx_filter_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [`AW-1:0] reg_addr = '0;
   logic [31:0] reg_wdata = '0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic ce = 1'b1;
   logic done_seen = 1'b0;
   logic [7:0] got [2048];
   logic [31:0] reg_rdata, d;
   mii_t mii;
   logic hit = 1'b0, keep = 1'b0, ctrl = 1'b0;
   logic [`CHW-1:0] mch = '0;
   logic mbv, fdone, facc, tdf;
   logic [7:0] mb;
   logic [`CHW-1:0] fch, tdc;
   frame_cls_t fcls;
   logic [15:0] flen;
   logic [`NCHAN-1:0] irq;
   logic [`NCHAN-1:0] irq_seen = '0;
   logic flag_seen = 1'b0;
   int failures = 0, n_tests = 0, cycles = 0, nb = 0, mx = 1518, n, ef = 8;
   logic [31:0] rs = 32'h0000_0022;
   logic [7:0] filt = 8'h00;

   always #20 sys_clk = ~sys_clk;

   mii_phy_model u_mii_phy_model (.mii(mii));

   rx_frame_filter_teardown u_rx_frame_filter_teardown (
      .sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .mii_rx_clk(mii.clk), .mii_rx_dv(mii.dv), .mii_rx_er(mii.er), .mii_rxd(mii.d),
      .match_hit(hit), .match_chan(mch), .addr_match_or_drop_bit(keep), .ctrl_frame(ctrl),
      .mem_byte_valid(mbv), .mem_byte(mb), .frame_done(fdone), .frame_accept(facc),
      .frame_chan(fch), .frame_class(fcls), .frame_len(flen), .rx_chan_irq(irq),
      .td_chan(tdc), .teardown_done_flag(tdf));

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Interrupt pulses last one cycle, so they are gathered here rather than polled.
   always @(posedge sys_clk) begin
      irq_seen <= irq_seen | irq;
      flag_seen <= flag_seen | tdf;
      done_seen <= done_seen | (fdone === 1'b1);
      if (mbv === 1'b1) begin
         got[nb] <= mb;
         nb <= nb + 1;
      end
      cycles <= cycles + 1;
      if (cycles == 50000) begin
         failures++;
         test_done();
      end
   end

   function automatic logic [31:0] rnd();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction : rnd

   function automatic logic [31:0] crc32(input logic [7:0] q[$]);
      logic [31:0] c;
      c = `CRC_INIT;
      foreach (q[i]) begin
         c ^= {24'h00_0000, q[i]};
         repeat (8) c = c[0] ? (c >> 1) ^ `CRC_POLY : c >> 1;
      end
      return ~c;
   endfunction : crc32

   function automatic frame_cls_t exp_cls(input int n, input bit e);
      if (n > mx) return e ? CLS_JABBER : CLS_OVERSIZE;
      if (n < 64) return e ? CLS_FRAGMENT : CLS_UNDERSIZE;
      return e ? CLS_JABBER : CLS_PROPER;
   endfunction : exp_cls

   function automatic int exp_len(input int n);
      return n > mx ? mx : (n <= 20 || filt[7]) ? n : n - 4;
   endfunction : exp_len

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr(input logic [`AW-1:0] a, input logic [31:0] v);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [`AW-1:0] a, output logic [31:0] v);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask : rd

   task automatic fr(input int n, input bit e, h, input int ch, input bit k, c,
                     input logic [7:0] f, input bit acc, input int ech);
      logic [7:0] q[$];
      logic [31:0] fcs;
      wr(`A_FILT, {24'h00_0000, f});
      filt = f;
      @(posedge sys_clk);
      hit <= h;
      mch <= ch[`CHW-1:0];
      keep <= k;
      ctrl <= c;
      repeat (n - 4) q.push_back(8'(rnd()));
      fcs = crc32(q);
      for (int i = 0; i < 4; i++) q.push_back(fcs[8 * i +: 8]);
      if (e) q[0] = ~q[0];
      // Clear the gathered state away from the edge, so the collector cannot undo it.
      #1;
      done_seen = 1'b0;
      nb = 0;
      u_mii_phy_model.send(q, e);
      for (int i = 0; i < 100 && done_seen !== 1'b1; i++) begin
         @(posedge sys_clk);
         #1;
      end
      chk(done_seen, 1'b1);
      chk(fcls, exp_cls(n, e));
      chk(facc, acc);
      if (acc) begin
         chk(fch, ech);
         chk(flen, exp_len(n));
         chk(nb, exp_len(n));
         for (int i = 0; i < exp_len(n); i++) begin
            chk(got[i], q[i]);
         end
      end
      $display("frame test of %0d bytes done", n);
   endtask : fr

   task automatic td(input int ch, input bit flag);
      #1;
      irq_seen = '0;
      flag_seen = 1'b0;
      wr(`A_TDOWN, ch);
      repeat (4) @(posedge sys_clk);
      #1;
      chk(irq_seen, 1 << ch);
      chk(flag_seen, flag);
      chk(tdc, ch);
      rd(`A_CP + 10'(4 * ch), d);
      chk(d, `TD_MARKER);
      rd(`A_HEAD + 10'(4 * ch), d);
      chk(d, 32'h0000_0000);
      rd(`A_CHEN, d);
      chk(d, 32'h0000_0006);
      wr(`A_CP + 10'(4 * ch), `TD_MARKER);
      $display("teardown test on channel %0d done", ch);
   endtask : td

   task automatic test_done();
      $display("checks %0d, mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : test_done

   ////////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (12) @(posedge sys_clk);
      rst_n <= 1'b1;
      rd(`A_MAXLEN, d);
      chk(d, 32'h0000_05EE);
      rd(10'h3FC, d);
      chk(d, 32'h0000_0000);
      wr(`A_FREE + 10'h004, 32'h0000_0005);
      wr(`A_FREE + 10'h004, 32'h0000_0003);
      rd(`A_FREE + 10'h004, d);
      chk(d, 32'h0000_0008);
      // A write while the clock enable is low must be lost.
      ce <= 1'b0;
      wr(`A_FREE + 10'h004, 32'h0000_0001);
      ce <= 1'b1;
      rd(`A_FREE + 10'h004, d);
      chk(d, 32'h0000_0008);
      wr(`A_FREE + 10'h008, 32'h0000_FFFF);
      wr(`A_FREE + 10'h008, 32'h0000_0001);
      rd(`A_FREE + 10'h008, d);
      chk(d, 32'h0000_FFFF);
      wr(`A_CHEN, 32'h0000_0006);
      $display("register test done");
      repeat (2) begin
         n = 64 + int'(rnd() & 32'h0000_000F);
         fr(n, 0, 1, 1, 1, 0, 8'h00, 1, 1);
         // One buffer holds 64 bytes, the block's default.
         ef -= (exp_len(n) + 63) / 64;
      end
      rd(`A_FREE + 10'h004, d);
      chk(d, ef);
      fr(20, 0, 1, 1, 1, 0, 8'h40, 1, 1);
      fr(64, 0, 1, 2, 1, 0, 8'h80, 1, 2);
      mx = 100;
      wr(`A_MAXLEN, 32'h0000_0064);
      fr(104, 0, 1, 1, 1, 0, 8'h18, 1, 1);
      fr(103, 1, 1, 1, 1, 0, 8'h18, 1, 1);
      fr(70, 1, 1, 1, 1, 0, 8'h18, 1, 1);
      fr(70, 0, 0, 0, 1, 0, 8'h0E, 1, 6);
      fr(70, 0, 0, 0, 1, 0, 8'h00, 0, 0);
      fr(70, 0, 1, 3, 1, 0, 8'h0E, 1, 6);
      fr(70, 0, 1, 1, 0, 0, 8'h18, 0, 0);
      fr(70, 0, 1, 1, 1, 1, 8'h0E, 0, 0);
      fr(70, 0, 1, 1, 1, 1, 8'h20, 1, 1);
      fr(40, 1, 0, 0, 1, 0, 8'h5E, 1, 6);
      wr(`A_HEAD + 10'h008, 32'h0000_1000);
      td(2, 1'b1);
      td(5, 1'b0);
      test_done();
   end
endmodule : testbench
`default_nettype wire
